// >>> hw/efc_pkg.sv
package efc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_PM0 = 10'h004;
  localparam logic [9:0] IDX_PRCR = 10'h00a;
  localparam logic [9:0] IDX_CFG = 10'h040;
  localparam logic [9:0] IDX_XADDR = 10'h041;
  localparam logic [9:0] IDX_XDATA = 10'h042;
  localparam logic [9:0] IDX_XCMD = 10'h043;
  localparam logic [9:0] IDX_STAT = 10'h044;
  // field positions
  localparam int PM0_MODE_LSB = 0;
  localparam int PM0_FMT_LSB = 4;
  localparam int PM0_PORT_BIT = 6;
  localparam int PRCR_PM_WE_BIT = 1;
  localparam int CFG_WAIT_BIT = 0;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_RD_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_W8_BIT = 2;
  // reset values
  localparam logic [7:0] PM0_RST = 8'h00;
  localparam logic [7:0] PRCR_RST = 8'h00;
  localparam logic CFG_WAIT_RST = 1'h0;
  // processor modes and bus formats
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_MPU = 2'h3;
  localparam logic [1:0] FMT_SEP = 2'h0;
  localparam logic [1:0] FMT_CS2 = 2'h1;
  localparam logic [1:0] FMT_CS1 = 2'h2;
  localparam logic [1:0] FMT_ALL = 2'h3;
  // areas multiplexed under the partial formats
  localparam logic [19:0] CS2_LO = 20'h08000;
  localparam logic [19:0] CS2_HI = 20'h27fff;
  localparam logic [19:0] CS1_LO = 20'h28000;
  localparam logic [19:0] CS1_HI = 20'h2ffff;
  // bus cycle timing in mclk cycles
  localparam logic [2:0] LATCH_CYC = 3'h2;
  localparam logic [2:0] STRB_CYC = 3'h2;
  localparam logic [2:0] SWAIT_CYC = 3'h2;
  // end phase long enough for read data to pass the pin synchroniser
  localparam logic [2:0] END_CYC = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LATCH = 3'b001,
    ST_STRB = 3'b011,
    ST_END = 3'b010
  } efc_state_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_b;
  } efc_port_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] fmt;
    logic port_io;
    logic wait_en;
  } efc_cfg_t;
endpackage

// >>> hw/efc_sync.sv
`timescale 1ns/1ns
module efc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> hw/efc_top.sv
// Overview of operation
// [RL1] strap low gives 16-bit, high 8-bit
// [RL2] board holds width strap constant
// [RL3] internal data path always 16 bits
// [RL4] mode bits 5:4 pick bus format
// [RL5] format 11 multiplexes whole space
// [RL6] separate 8-bit frees high data port
// [RL7] software wait on separate accesses
// [RL8] 8-bit mux: d0-7 share a0-7
// [RL9] 16-bit mux: d0-7 share a1-8
// [RL10] software uses even byte addresses
// [RL11] drive address latch strobe pin
// [RL12] multiplexed access needs software wait
// [RL13] whole-space mux only at 8-bit
// [RL14] separate after reset; no whole-space mpu
// [RL15] whole-space mux frees upper address pins
// [RL16] bus pins only in expansion modes
// [RL17] software wait works in every mode
// [RL18] port select bit frees upper pins
// [RL19] twenty address lines, one megabyte
// [RL20] address undefined until first access
// [RL21] mode writes need protect bit one
// [RL22] address stable through strobe fall
// [RL23] address in latch phase, then data
`timescale 1ns/1ns
module efc_top
  import efc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic width_strap,
  input wire logic [7:0] low_data_port_in,
  input wire logic [7:0] high_data_port_in,
  input wire logic [7:0] addr_lo_port_in,
  input wire logic [7:0] addr_mid_port_in,
  output efc_port_t low_data_port,
  output efc_port_t high_data_port,
  output efc_port_t addr_lo_port,
  output efc_port_t addr_mid_port,
  output efc_port_t upper_address_port_pins,
  output logic latch_strobe_pin,
  output logic latch_strobe_oe_b,
  output logic rd_b,
  output logic wr_b,
  output logic strobe_oe_b
);
  logic [32:0] sync_s;
  logic width8;
  logic [7:0] p0_s, p1_s, p2_s, p3_s;
  logic [7:0] pm0_q, prcr_q;
  logic wait_en_q;
  logic [19:0] xaddr_q;
  logic [15:0] xdata_q, rdata_q;
  logic err_q, addr_live_q, acc_mux_q, acc_rd_q;
  logic wr_pend_q;
  logic [9:0] wr_idx_q;
  efc_state_t state_q;
  logic [2:0] cnt_q;
  efc_cfg_t cfg;
  logic [1:0] fmt_eff;
  logic ext_on, mux_req, go, start, refuse, addr_ok;
  logic [9:0] idx;
  logic [2:0] strb_len;
  logic [31:0] rd_d;
  efc_port_t p0_d, p1_d, p2_d, p3_d, up_d;

  efc_sync #(.W(33)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({width_strap, low_data_port_in, high_data_port_in, addr_lo_port_in, addr_mid_port_in}),
    .q(sync_s)
  );

  function automatic logic is_mux(input logic [1:0] fmt, input logic [19:0] a);
    is_mux = (fmt == FMT_ALL) || (fmt == FMT_CS2 && a >= CS2_LO && a <= CS2_HI) ||
             (fmt == FMT_CS1 && a >= CS1_LO && a <= CS1_HI);
  endfunction

  assign {width8, p0_s, p1_s, p2_s, p3_s} = sync_s; // RL1
  assign cfg = '{mode: pm0_q[PM0_MODE_LSB+:2], fmt: pm0_q[PM0_FMT_LSB+:2],
                 port_io: pm0_q[PM0_PORT_BIT], wait_en: wait_en_q};
  // whole-space mux falls back to separate at 16 bits or in mpu mode
  assign fmt_eff = (cfg.fmt == FMT_ALL && (cfg.mode == MODE_MPU || !width8)) ?
                   FMT_SEP : cfg.fmt; // RL13 RL14 RL4
  assign ext_on = (cfg.mode != MODE_SINGLE); // RL16
  assign mux_req = is_mux(fmt_eff, xaddr_q); // RL5
  assign go = wr_pend_q && (wr_idx_q == IDX_XCMD) && hwdata[CMD_GO_BIT] &&
              (state_q == ST_IDLE);
  assign refuse = !ext_on || (mux_req && !cfg.wait_en); // RL12
  assign start = go && !refuse;
  assign strb_len = cfg.wait_en ? STRB_CYC + SWAIT_CYC : STRB_CYC; // RL7 RL17
  assign idx = haddr[11:2];
  assign addr_ok = (haddr[31:12] == 20'h00000);

  // ahb-lite slave: zero wait, always okay
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_q <= hsel && htrans[1] && hwrite && addr_ok;
        wr_idx_q <= idx;
        if (hsel && htrans[1] && !hwrite) begin
          hrdata <= addr_ok ? rd_d : 32'h00000000;
        end
      end
    end
  end

  always_comb begin
    rd_d = 32'h00000000;
    case (idx)
      IDX_PM0: rd_d = {24'h000000, pm0_q};
      IDX_PRCR: rd_d = {24'h000000, prcr_q};
      IDX_CFG: rd_d = {31'h00000000, wait_en_q};
      IDX_XADDR: rd_d = {12'h000, xaddr_q};
      IDX_XDATA: rd_d = {16'h0000, rdata_q};
      IDX_STAT: begin
        rd_d[STAT_BUSY_BIT] = (state_q != ST_IDLE);
        rd_d[STAT_ERR_BIT] = err_q;
        rd_d[STAT_W8_BIT] = width8;
      end
      default: rd_d = 32'h00000000;
    endcase
  end

  // configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pm0_q <= PM0_RST; // RL14
      prcr_q <= PRCR_RST;
      wait_en_q <= CFG_WAIT_RST;
    end else if (wr_pend_q) begin
      if (wr_idx_q == IDX_PM0 && prcr_q[PRCR_PM_WE_BIT]) begin
        pm0_q <= hwdata[7:0]; // RL21
      end
      if (wr_idx_q == IDX_PRCR) begin
        prcr_q <= hwdata[7:0];
      end
      if (wr_idx_q == IDX_CFG) begin
        wait_en_q <= hwdata[CFG_WAIT_BIT];
      end
    end
  end

  // access address and write data, 16 bits inside whatever the pins carry
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      xaddr_q <= 20'h00000;
      xdata_q <= 16'h0000;
    end else if (wr_pend_q && state_q == ST_IDLE) begin
      if (wr_idx_q == IDX_XADDR) begin
        xaddr_q <= hwdata[19:0]; // RL19
      end
      if (wr_idx_q == IDX_XDATA) begin
        xdata_q <= hwdata[15:0]; // RL3
      end
    end
  end

  // refused-access flag; a new refusal wins over a clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      err_q <= 1'b0;
    end else if (go && refuse) begin
      err_q <= 1'b1;
    end else if (wr_pend_q && wr_idx_q == IDX_STAT && hwdata[STAT_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  // address pins stay released after entering a bus mode until an access
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      addr_live_q <= 1'b0;
    end else if (!ext_on) begin
      addr_live_q <= 1'b0;
    end else if (start) begin
      addr_live_q <= 1'b1; // RL20
    end
  end

  // bus cycle sequencer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      acc_mux_q <= 1'b0;
      acc_rd_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 3'h0;
          if (start) begin
            acc_mux_q <= mux_req;
            acc_rd_q <= hwdata[CMD_RD_BIT];
            state_q <= mux_req ? ST_LATCH : ST_STRB;
          end
        end
        ST_LATCH: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == LATCH_CYC - 3'h1) begin
            cnt_q <= 3'h0;
            state_q <= ST_STRB;
          end
        end
        ST_STRB: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == strb_len - 3'h1) begin
            cnt_q <= 3'h0;
            state_q <= ST_END;
          end
        end
        // read data sampled late: synchronised pins lag the strobe
        ST_END: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == END_CYC - 3'h1) begin
            state_q <= ST_IDLE;
            if (acc_rd_q) begin
              if (!acc_mux_q) begin
                rdata_q <= width8 ? {8'h00, p0_s} : {p1_s, p0_s}; // RL6
              end else if (width8) begin
                rdata_q <= {8'h00, p2_s}; // RL8
              end else begin
                rdata_q <= {p1_s, p3_s[0], p2_s[7:1]}; // RL9
              end
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pin function map
  always_comb begin
    p0_d = '{dout: 8'h00, oe_b: 8'hff};
    p1_d = '{dout: 8'h00, oe_b: 8'hff};
    p2_d = '{dout: 8'h00, oe_b: 8'hff};
    p3_d = '{dout: 8'h00, oe_b: 8'hff};
    up_d = '{dout: 8'h00, oe_b: 8'hff};
    if (ext_on && addr_live_q) begin
      p2_d = '{dout: xaddr_q[7:0], oe_b: 8'h00};
      if (fmt_eff == FMT_ALL) begin
        p3_d = '{dout: {7'h00, xaddr_q[8]}, oe_b: 8'hfe}; // RL15
      end else begin
        p3_d = '{dout: xaddr_q[15:8], oe_b: 8'h00};
        if (!cfg.port_io) begin
          up_d = '{dout: {4'h0, xaddr_q[19:16]}, oe_b: 8'hf0}; // RL18
        end
      end
      if (state_q == ST_LATCH && !width8) begin
        {p3_d.dout[0], p2_d.dout[7:1]} = xaddr_q[8:1]; // RL9
      end
      if (state_q == ST_STRB && acc_mux_q) begin
        if (width8) begin
          p2_d.dout = xdata_q[7:0]; // RL8 RL23
          p2_d.oe_b = acc_rd_q ? 8'hff : 8'h00;
        end else begin
          {p3_d.dout[0], p2_d.dout[7:1]} = xdata_q[7:0]; // RL9 RL23
          {p3_d.oe_b[0], p2_d.oe_b[7:1]} = acc_rd_q ? 8'hff : 8'h00;
          p1_d = '{dout: xdata_q[15:8], oe_b: acc_rd_q ? 8'hff : 8'h00};
        end
      end
      if (state_q == ST_STRB && !acc_mux_q && !acc_rd_q) begin
        p0_d = '{dout: xdata_q[7:0], oe_b: 8'h00};
        if (!width8) begin
          p1_d = '{dout: xdata_q[15:8], oe_b: 8'h00}; // RL6
        end
      end
    end
  end

  // every pin output comes from a register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      low_data_port <= '{dout: 8'h00, oe_b: 8'hff};
      high_data_port <= '{dout: 8'h00, oe_b: 8'hff};
      addr_lo_port <= '{dout: 8'h00, oe_b: 8'hff};
      addr_mid_port <= '{dout: 8'h00, oe_b: 8'hff};
      upper_address_port_pins <= '{dout: 8'h00, oe_b: 8'hff};
      latch_strobe_pin <= 1'b0;
      latch_strobe_oe_b <= 1'b1;
      rd_b <= 1'b1;
      wr_b <= 1'b1;
      strobe_oe_b <= 1'b1;
    end else begin
      low_data_port <= p0_d;
      high_data_port <= p1_d;
      addr_lo_port <= p2_d;
      addr_mid_port <= p3_d;
      upper_address_port_pins <= up_d;
      // strobe falls one cycle before the lines turn to data
      latch_strobe_pin <= (state_q == ST_LATCH) && (cnt_q < LATCH_CYC - 3'h1); // RL11 RL22
      latch_strobe_oe_b <= !ext_on; // RL16
      rd_b <= !(state_q == ST_STRB && acc_rd_q);
      wr_b <= !(state_q == ST_STRB && !acc_rd_q);
      strobe_oe_b <= !ext_on;
    end
  end

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  logic [2:0] strb_run_q;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      strb_run_q <= 3'h0;
    end else begin
      strb_run_q <= (state_q == ST_STRB) ? strb_run_q + 3'h1 : 3'h0;
    end
  end

  AST_SEP_WIDTH: assert property ( // RL6
    (state_q == ST_STRB && !acc_mux_q && !acc_rd_q && ext_on) |=>
      (high_data_port.oe_b == (width8 ? 8'hff : 8'h00)))
    else $error("high data port drive does not match width");
  AST_LATCH_ONLY_MUX: assert property ( // RL4
    (state_q == ST_LATCH) |-> acc_mux_q)
    else $error("latch phase on a separate access");
  AST_ALL_UPPER_FREE: assert property ( // RL15
    (fmt_eff == FMT_ALL) |=> (upper_address_port_pins.oe_b == 8'hff))
    else $error("upper pins driven under whole-space mux");
  AST_STROBE_CAUSE: assert property ( // RL11
    $rose(latch_strobe_pin) |-> ($past(state_q) == ST_LATCH) && acc_mux_q)
    else $error("latch strobe without latch phase");
  AST_REFUSE_NOWAIT: assert property ( // RL12
    (go && ext_on && mux_req && !cfg.wait_en) |=> (state_q == ST_IDLE) && err_q)
    else $error("multiplexed access without software wait");
  AST_RESET_SEP: assert property ( // RL14
    @(posedge mclk) disable iff (1'b0) $rose(rst_b) |-> (pm0_q[PM0_FMT_LSB+:2] == FMT_SEP))
    else $error("format not separate after reset");
  AST_SINGLE_FREE: assert property ( // RL16
    (!ext_on) |=> (addr_lo_port.oe_b == 8'hff) && (low_data_port.oe_b == 8'hff) && rd_b)
    else $error("bus pins driven in single-chip mode");
  AST_PROTECT: assert property ( // RL21
    (wr_pend_q && wr_idx_q == IDX_PM0 && !prcr_q[PRCR_PM_WE_BIT]) |=> $stable(pm0_q))
    else $error("mode register written without protect bit");
  AST_WAIT_LEN: assert property ( // RL7
    (state_q == ST_STRB && cfg.wait_en && $stable(cfg.wait_en)) ##1 (state_q == ST_END)
      |-> ($past(strb_run_q) == STRB_CYC + SWAIT_CYC - 3'h1))
    else $error("strobe length ignores software wait");
  AST_MUX_TURN: assert property ( // RL23
    (state_q == ST_STRB && acc_mux_q && acc_rd_q && width8) |=> (addr_lo_port.oe_b == 8'hff))
    else $error("mux lines not released for read data");

  COV_SEP_RD: cover property ((state_q == ST_END) && !acc_mux_q && acc_rd_q);
  COV_MUX8_WR: cover property ((state_q == ST_END) && acc_mux_q && width8 && !acc_rd_q);
  COV_MUX16: cover property ((state_q == ST_END) && acc_mux_q && !width8);
  COV_REFUSED: cover property (go && refuse);
endmodule

// >>> dv/efc_ext_mem.sv
`timescale 1ns/1ns
module efc_ext_mem
  import efc_pkg::*;
(
  input wire logic mclk,
  input wire efc_port_t low_data_port,
  input wire efc_port_t high_data_port,
  input wire efc_port_t addr_lo_port,
  input wire logic latch_strobe_pin,
  input wire logic rd_b,
  input wire logic wr_b,
  output logic [7:0] low_data_port_in,
  output logic [7:0] high_data_port_in,
  output logic [7:0] addr_lo_port_in
);
  logic [15:0] mem_q [256];
  logic [15:0] last_q = 16'h0000;
  logic [7:0] adr_q = 8'h00;
  logic mux_q = 1'b0;
  logic [7:0] a;
  // address captured as the latch strobe falls
  always @(negedge latch_strobe_pin) begin
    if (addr_lo_port.oe_b === 8'h00 && rd_b === 1'b1 && wr_b === 1'b1) begin
      adr_q <= addr_lo_port.dout;
      mux_q <= 1'b1;
    end
  end
  always @(posedge wr_b or posedge rd_b) begin
    mux_q <= 1'b0;
  end
  assign a = mux_q ? adr_q : addr_lo_port.dout;
  // last strobe cycle wins for writes
  always @(posedge mclk) begin
    if (wr_b === 1'b0) begin
      if (mux_q) begin
        mem_q[adr_q] <= {8'h00, addr_lo_port.dout};
      end else begin
        mem_q[a] <= {high_data_port.dout, low_data_port.dout};
      end
    end
    if (rd_b === 1'b0) begin
      last_q <= mem_q[a];
    end
  end
  // released lines show the inverse of the last value
  assign low_data_port_in = (!rd_b && !mux_q) ? mem_q[a][7:0] : ~last_q[7:0];
  assign high_data_port_in = (!rd_b && !mux_q) ? mem_q[a][15:8] : ~last_q[15:8];
  assign addr_lo_port_in = (!rd_b && mux_q) ? mem_q[a][7:0] : ~last_q[7:0];
endmodule

// >>> dv/efc_top_tb.sv
`timescale 1ns/1ns
module efc_top_tb;
  import efc_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic width_strap = 1'b0;
  logic lat_seen = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp, latch_strobe_pin, latch_strobe_oe_b, rd_b, wr_b, strobe_oe_b;
  logic [7:0] p0_in, p1_in, p2_in;
  efc_port_t lo_p, hi_p, a2_p, a3_p, up_p;
  int err_total = 0;
  int cmp_count = 0;

  initial begin
    forever #4 mclk = ~mclk;
  end

  efc_top DUT (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .width_strap(width_strap),
    .low_data_port_in(p0_in), .high_data_port_in(p1_in), .addr_lo_port_in(p2_in),
    .addr_mid_port_in(8'h00), .low_data_port(lo_p), .high_data_port(hi_p),
    .addr_lo_port(a2_p), .addr_mid_port(a3_p), .upper_address_port_pins(up_p),
    .latch_strobe_pin(latch_strobe_pin), .latch_strobe_oe_b(latch_strobe_oe_b),
    .rd_b(rd_b), .wr_b(wr_b), .strobe_oe_b(strobe_oe_b));

  efc_ext_mem mem (.mclk(mclk), .low_data_port(lo_p), .high_data_port(hi_p),
    .addr_lo_port(a2_p), .latch_strobe_pin(latch_strobe_pin), .rd_b(rd_b), .wr_b(wr_b),
    .low_data_port_in(p0_in), .high_data_port_in(p1_in), .addr_lo_port_in(p2_in));

  always @(posedge mclk) begin
    if (latch_strobe_pin === 1'b1) begin
      lat_seen <= 1'b1;
    end
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    complete_run;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic [31:0] x;
    bus({20'h0, i, 2'h0}, 1'b1, d, x);
  endtask

  task automatic rd(input logic [9:0] i, output logic [31:0] d);
    bus({20'h0, i, 2'h0}, 1'b0, 32'h0, d);
  endtask

  task automatic do_reset(input logic s);
    @(posedge mclk);
    rst_b <= 1'b0;
    width_strap <= s;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic wait_idle;
    logic [31:0] s;
    repeat (40) begin
      rd(IDX_STAT, s);
      if (s[STAT_BUSY_BIT] === 1'b0) break;
    end
    chk("busy", 32'h0, s[STAT_BUSY_BIT]);
  endtask

  task automatic wait_wr;
    repeat (30) begin
      @(negedge mclk);
      if (wr_b === 1'b0) break;
    end
  endtask

  task automatic wait_lat;
    repeat (30) begin
      @(negedge mclk);
      if (latch_strobe_pin === 1'b1) break;
    end
  endtask

  task automatic t_regs;
    logic [31:0] d;
    do_reset(1'b0);
    chk("port_oe", 32'hffff, {lo_p.oe_b, hi_p.oe_b});
    chk("strobes", 32'h6, {rd_b, wr_b, latch_strobe_pin});
    chk("hresp", 32'h0, {hreadyout, hresp} ^ 2'b10);
    chk("strobe_oe_single", 32'h3, {strobe_oe_b, latch_strobe_oe_b});
    rd(IDX_PM0, d);
    chk("pm0_rst", 32'h0, d);
    rd(IDX_STAT, d);
    chk("width8", 32'h0, d[STAT_W8_BIT]);
    wr(IDX_PM0, 32'h1);
    rd(IDX_PM0, d);
    chk("pm0_locked", 32'h0, d);
    wr(IDX_PRCR, 32'h2);
    wr(IDX_PM0, 32'h1);
    rd(IDX_PM0, d);
    chk("pm0_open", 32'h1, d);
    chk("addr_rel", 32'hff, a2_p.oe_b);
    bus(32'h0001_0010, 1'b0, 32'h0, d);
    chk("unmapped", 32'h0, d);
    wr(IDX_PM0, 32'h0);
    wr(IDX_XCMD, 32'h1);
    rd(IDX_STAT, d);
    chk("single_err", 32'h1, d[STAT_ERR_BIT]);
    chk("single_strb", 32'h3, {rd_b, wr_b});
  endtask

  task automatic t_sep(input logic s, input logic [7:0] pm0, input logic w);
    logic [31:0] d;
    int n;
    do_reset(s);
    rd(IDX_STAT, d);
    chk("width8", s, d[STAT_W8_BIT]);
    wr(IDX_PRCR, 32'h2);
    wr(IDX_PM0, pm0);
    wr(IDX_CFG, w);
    wr(IDX_XADDR, 32'h12345);
    wr(IDX_XDATA, 32'ha55a);
    lat_seen <= 1'b0;
    wr(IDX_XCMD, 32'h1);
    wait_wr;
    chk("low_port", 32'h005a, {lo_p.oe_b, lo_p.dout});
    chk("high_port", s ? 8'hff : 8'ha5, s ? hi_p.oe_b : hi_p.dout);
    chk("address", pm0[6] ? 32'h02345 : 32'h12345, {up_p.dout[3:0], a3_p.dout, a2_p.dout});
    chk("strobe_oe", 32'h0, {strobe_oe_b, latch_strobe_oe_b});
    chk("upper_oe", pm0[6] ? 4'hf : 4'h0, up_p.oe_b[3:0]);
    n = 0;
    while (wr_b === 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("strobe_len", w ? STRB_CYC + SWAIT_CYC : STRB_CYC, n);
    wait_idle;
    wr(IDX_XCMD, 32'h3);
    wait_idle;
    rd(IDX_XDATA, d);
    chk("read_data", s ? 16'h005a : 16'ha55a, s ? {8'h00, d[7:0]} : d[15:0]);
    chk("no_latch", 32'h0, lat_seen);
  endtask

  task automatic t_mux8;
    logic [31:0] d;
    do_reset(1'b1);
    wr(IDX_PRCR, 32'h2);
    wr(IDX_PM0, 32'h31);
    wr(IDX_XADDR, 32'hc7);
    wr(IDX_XDATA, 32'h3c);
    wr(IDX_XCMD, 32'h1);
    rd(IDX_STAT, d);
    chk("no_wait_err", 32'h1, d[STAT_ERR_BIT]);
    wr(IDX_CFG, 32'h1);
    wr(IDX_XCMD, 32'h1);
    wait_lat;
    chk("mux_addr", 32'h00c7, {a2_p.oe_b, a2_p.dout});
    chk("upper_io", 32'hf, up_p.oe_b[3:0]);
    wait_wr;
    chk("mux_data", 32'h3c, a2_p.dout);
    wait_idle;
    wr(IDX_XCMD, 32'h3);
    wait_idle;
    rd(IDX_XDATA, d);
    chk("mux_read", 32'h3c, d[7:0]);
  endtask

  task automatic t_mux16;
    do_reset(1'b0);
    wr(IDX_PRCR, 32'h2);
    wr(IDX_PM0, 32'h11);
    wr(IDX_CFG, 32'h1);
    wr(IDX_XADDR, 32'h08156);
    wr(IDX_XDATA, 32'hbe3c);
    wr(IDX_XCMD, 32'h1);
    wait_lat;
    chk("m16_addr", 32'h156, {a3_p.dout[0], a2_p.dout});
    wait_wr;
    chk("m16_data", 32'hbe3c, {hi_p.dout, a3_p.dout[0], a2_p.dout[7:1]});
    wait_idle;
  endtask

  initial begin
    t_regs;
    t_sep(1'b0, 8'h01, 1'b0);
    t_sep(1'b1, 8'h41, 1'b1);
    t_sep(1'b0, 8'h31, 1'b0);
    t_sep(1'b1, 8'h33, 1'b0);
    t_mux8;
    t_mux16;
    complete_run;
  end
endmodule
